/* test/link_partner.sv */
`timescale 1ns/1ps

module link_partner
	import phy_link_pkg::*;
(
	input wire logic sys_clk_i,
	input wire line_rx_t ctl_i,
	input wire line_tx_t line_tx_i,
	output line_rx_t line_rx_o
);

	logic fv;
	logic [15:0] wv;

	initial begin
		fv = 1'h0;
		wv = 16'h0000;
		line_rx_o = '0;
	end

	// Idle data and code-word lines keep toggling so a stale value never looks valid.
	always @(posedge sys_clk_i) begin
		line_rx_o <= ctl_i;
		line_rx_o.flp_valid <= fv;
		line_rx_o.flp_word <= fv ? wv : ~line_rx_o.flp_word;
		if (!ctl_i.dv) begin
			line_rx_o.data <= ~line_rx_o.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Acknowledged words go out only once the device shows its own acknowledge, with a bounded wait.
	task automatic send(input logic [15:0] w, input int n);
		int t;
		t = 0;
		while (w[ADV_ACK] && line_tx_i.flp_word[ADV_ACK] !== 1'h1 && t < 100) begin
			@(posedge sys_clk_i);
			t++;
		end
		repeat (n) begin
			@(posedge sys_clk_i);
			fv <= 1'h1;
			wv <= w;
			@(posedge sys_clk_i);
			fv <= 1'h0;
			repeat (3) @(posedge sys_clk_i);
		end
	endtask

endmodule

/* test/phy_link_control_tb.sv */
`timescale 1ns/1ps

module phy_link_control_tb;
	import phy_link_pkg::*;

	localparam int JL = 64;
	localparam int JI = 128;
	logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, tx_en_i;
	logic [2:0] straps;
	logic [4:0] reg_addr_i;
	logic [15:0] reg_wdata_i, reg_rdata_o;
	logic [3:0] txd_i, mii_rxd_o;
	line_rx_t line_rx, ctl;
	line_tx_t line_tx;
	logic mii_col_o, mii_rx_dv_o, link_up_o, speed_100_o, full_duplex_o, link_led, act_led, phy_irq_o;
	int miscompares, n_checks, cyc;

	phy_link_control #(.JABBER_LIMIT(32'h40), .JABBER_IDLE(32'h80), .AN_TIMEOUT(32'h100)) DUT (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .technology_straps_i(straps), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.tx_en_i(tx_en_i), .txd_i(txd_i), .line_rx_i(line_rx), .line_tx_o(line_tx), .mii_col_o(mii_col_o),
		.mii_rxd_o(mii_rxd_o), .mii_rx_dv_o(mii_rx_dv_o), .link_up_o(link_up_o), .speed_100_o(speed_100_o),
		.full_duplex_o(full_duplex_o), .link_indicator_pin_o(link_led), .activity_indicator_pin_o(act_led),
		.phy_irq_o(phy_irq_o));

	link_partner partner (.sys_clk_i(sys_clk_i), .ctl_i(ctl), .line_tx_i(line_tx), .line_rx_o(line_rx));

	initial begin
		sys_clk_i = 1'h0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'h0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e, input string n);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'h0;
		#1 chk16(n, e, reg_rdata_o & m);
	endtask

	// The window skips the first 30 cycles (750 ns), so an early pulse shows up as a short count.
	task automatic hb(input logic c, input int e);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		tx_en_i <= 1'h1;
		ctl.collision <= c;
		tick(10);
		tx_en_i <= 1'h0;
		ctl.collision <= 1'h0;
		tick(30);
		repeat (80) begin
			@(posedge sys_clk_i);
			#1 if (mii_col_o === 1'h1) n++;
		end
		chk16("heartbeat cycles", 16'(e), 16'(n));
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			test_done;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_i = 1'h1;
		reg_wr_i = 1'h0;
		reg_rd_i = 1'h0;
		reg_addr_i = 5'h00;
		reg_wdata_i = 16'h0000;
		tx_en_i = 1'h0;
		txd_i = 4'h0;
		straps = 3'h7;
		ctl = '0;
		ctl.link_ok = 1'h1;
		tick(8);
		rst_i <= 1'h0;
		tick(2);
		#1 chk1("link pulses", 1'h1, line_tx.link_pulse);
		chk1("flp send", 1'h1, line_tx.flp_send);
		chk16("flp word", 16'h01E1, line_tx.flp_word);
		rd(REG_BCTL, 16'hFFFF, 16'h1000, "basic control");
		rd(REG_ADV, 16'hFFFF, 16'h01E1, "advertisement");
		rd(REG_LED, 16'hFFFF, 16'h0010, "led config");
		wr(REG_IRQ, 16'hFF00);
		partner.send(16'h0061, 3);
		rd(REG_PARTNER, 16'hFFFF, 16'h0061, "partner word");
		partner.send(16'h4061, 3);
		tick(2);
		#1 chk1("link up", 1'h1, link_up_o);
		chk1("full duplex", 1'h1, full_duplex_o);
		chk1("speed 100", 1'h0, speed_100_o);
		chk1("link led", 1'h1, link_led);
		chk1("irq out", 1'h1, phy_irq_o);
		rd(REG_DIAG, 16'h1C00, 16'h0800, "diag result");
		rd(REG_IRQ, 16'hFF01, 16'hFF01, "irq status");
		rd(REG_IRQ, 16'hFFFF, 16'hFF00, "irq cleared");
		tick(1);
		#1 chk1("irq out low", 1'h0, phy_irq_o);
		wr(REG_LED, 16'h0002);
		tick(1);
		#1 chk1("led speed", 1'h0, link_led);
		wr(REG_LED, 16'h0010);
		wr(REG_BCTL, 16'h1200);
		tick(2);
		#1 chk1("link dropped", 1'h0, link_up_o);
		chk1("flp restart", 1'h1, line_tx.flp_send);
		rd(REG_BCTL, 16'hFFFF, 16'h1000, "restart clears");
		tick(1);
		ctl.idle10 <= 1'h1;
		tick(4);
		#1 chk1("idle link", 1'h1, link_up_o);
		chk1("idle half", 1'h0, full_duplex_o);
		chk1("idle speed", 1'h0, speed_100_o);
		chk1("idle pulses", 1'h1, line_tx.link_pulse);
		hb(1'h0, 40);
		hb(1'h1, 0);
		wr(REG_VCTL, 16'h0800);
		hb(1'h0, 0);
		wr(REG_VCTL, 16'h0400);
		tx_en_i <= 1'h1;
		txd_i <= 4'hA;
		tick(2);
		#1 chk16("loop rxd", 16'h000A, {12'h000, mii_rxd_o});
		chk1("loop dv", 1'h1, mii_rx_dv_o);
		chk1("activity led", 1'h1, act_led);
		tick(1);
		ctl.collision <= 1'h1;
		ctl.data <= 4'h5;
		ctl.dv <= 1'h1;
		tick(3);
		#1 chk16("collision rxd", 16'h0005, {12'h000, mii_rxd_o});
		tick(1);
		tx_en_i <= 1'h0;
		ctl.collision <= 1'h0;
		ctl.dv <= 1'h0;
		ctl.inverted <= 1'h1;
		tick(4);
		#1 chk1("auto pol", 1'h1, line_tx.pol_inv);
		rd(REG_VCTL, 16'h0030, 16'h0010, "pol report");
		wr(REG_VCTL, 16'h0020);
		tick(2);
		#1 chk1("manual pol", 1'h0, line_tx.pol_inv);
		rd(REG_VCTL, 16'h0030, 16'h0020, "manual read");
		wr(REG_VCTL, 16'h0030);
		tick(2);
		#1 chk1("manual rev", 1'h1, line_tx.pol_inv);
		wr(REG_VCTL, 16'h0000);
		tx_en_i <= 1'h1;
		tick(JL + 16);
		#1 chk1("jabber", 1'h0, line_tx.tx_en);
		tick(1);
		tx_en_i <= 1'h0;
		tick(JI - 28);
		tx_en_i <= 1'h1;
		tick(3);
		#1 chk1("jabber held", 1'h0, line_tx.tx_en);
		tick(1);
		tx_en_i <= 1'h0;
		tick(JI + 12);
		tx_en_i <= 1'h1;
		tick(3);
		#1 chk1("jabber over", 1'h1, line_tx.tx_en);
		chk16("line txd", 16'h000A, {12'h000, line_tx.txd});
		tick(1);
		tx_en_i <= 1'h0;
		wr(REG_ADV, 16'h0021);
		wr(REG_ADV, 16'h01E1);
		rd(REG_ADV, 16'hFFFF, 16'h0021, "adv only clears");
		wr(REG_IRQ, 16'h0000);
		rd(REG_IRQ, 16'hFF00, 16'h0000, "irq enables");
		wr(REG_BCTL, 16'h0000);
		tick(2);
		#1 chk1("aneg off", 1'h0, line_tx.flp_send);
		rd(REG_BCTL, 16'hFFFF, 16'h0000, "aneg cleared");
		tick(1);
		ctl.idle10 <= 1'h0;
		ctl.link_ok <= 1'h0;
		wr(REG_BCTL, 16'h1000);
		tick(300);
		rd(REG_DIAG, 16'h1000, 16'h1000, "aneg failed");
		chk1("fail restart", 1'h1, line_tx.flp_send);
		chk1("masked irq", 1'h0, phy_irq_o);
		rd(REG_IRQ, 16'hFFFF, 16'h0000, "masked status");
		tick(1);
		straps <= 3'h1;
		rst_i <= 1'h1;
		tick(8);
		rst_i <= 1'h0;
		tick(2);
		rd(REG_ADV, 16'hFFFF, 16'h0021, "strap 10 half");
		test_done;
	end

endmodule

/* verilog/phy_link_control.sv */
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - Jabber timeout disables line transmission.
// - Jabber ends after 500 ms MII idle.
// - Link pulses during negotiation and 10M idle.
// - Heartbeat on collision 1 us after 10M transmit ends.
// - Vendor bit 11 disables the heartbeat.
// - Automatic polarity by default, reported back.
// - Manual mode: reverse bit sets polarity.
// - Natural loopback returns transmit data.
// - Collision during loopback returns line data.
// - Negotiation enabled at reset, software clears.
// - Advertisement sent; tech bits from straps.
// - Software may only clear advertised bits.
// - Start pulses at power-on, loss, restart.
// - Idle pattern gives half duplex, matching speed.
// - Three matching words stored as partner.
// - Three acknowledged words pick best technology.
// - Diagnostic bits report speed and duplex.
// - Failure sets diagnostic bit and restarts.
// - Writing restart bit restarts negotiation.
// - Indicators default link and activity, configurable.
// - Interrupt while any status bit set.
// - Enable bits gate each interrupt condition.
// - Reading interrupt register clears status.
module phy_link_control
	import phy_link_pkg::*;
#(
	parameter logic [31:0] JABBER_LIMIT = JABBER_LIMIT_CYC,
	parameter logic [31:0] JABBER_IDLE = JABBER_IDLE_CYC,
	parameter logic [31:0] AN_TIMEOUT = AN_TIMEOUT_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [2:0] technology_straps_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic tx_en_i,
	input wire logic [3:0] txd_i,
	input wire line_rx_t line_rx_i,
	output line_tx_t line_tx_o,
	output logic mii_col_o,
	output logic [3:0] mii_rxd_o,
	output logic mii_rx_dv_o,
	output logic link_up_o,
	output logic speed_100_o,
	output logic full_duplex_o,
	output logic link_indicator_pin_o,
	output logic activity_indicator_pin_o,
	output logic phy_irq_o
);

	typedef struct packed {
		an_state_t an;
		logic aneg_en;
		logic force_speed;
		logic force_dup;
		logic [3:0] adv_tech;
		logic [15:0] partner;
		logic [15:0] last_word;
		logic [1:0] match_cnt;
		logic [31:0] an_timer;
		logic an_fail;
		logic sqe_dis;
		logic loop_en;
		logic manual_pol;
		logic pol_rev;
		logic [7:0] irq_en;
		logic [7:0] irq_stat;
		logic [7:0] led_cfg;
		logic [31:0] jab_cnt;
		logic jabber;
		logic tx_en_d;
		logic col_seen;
		logic sqe_run;
		logic [6:0] sqe_cnt;
		logic [15:0] rdata;
		line_tx_t tx;
		logic mii_col;
		logic [3:0] mii_rxd;
		logic mii_dv;
		logic link_up;
		logic speed100;
		logic full_dup;
		logic link_led;
		logic act_led;
		logic irq;
	} state_t;

	state_t s;
	state_t n;
	logic [7:0] ev;

	function automatic state_t reset_state(input logic [2:0] straps);
		state_t r;
		r = '0;
		r.aneg_en = 1'b1;
		r.an = AN_ABILITY;
		r.adv_tech = (straps == STRAP_ALL) ? TECH_ALL : TECH_10HD;
		r.led_cfg = LED_CFG_RESET;
		return r;
	endfunction

	function automatic logic led_sel(input logic [3:0] code, input state_t x, input logic act);
		case (code)
			LED_LINK: led_sel = x.link_up;
			LED_ACT: led_sel = act;
			LED_SPEED: led_sel = x.speed100;
			LED_DUPLEX: led_sel = x.full_dup;
			LED_COL: led_sel = x.mii_col;
			default: led_sel = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic restart;
		logic go;
		logic fail;
		logic pol;
		logic lb;
		logic [15:0] word;
		logic [3:0] common;
		logic [15:0] r;
		restart = 1'b0;
		go = 1'b0;
		fail = 1'b0;
		pol = 1'b0;
		lb = 1'b0;
		word = '0;
		common = '0;
		r = '0;
		n = s;
		ev = '0;

		if (reg_wr_i) begin
			if (reg_addr_i == REG_BCTL) begin
				n.aneg_en = reg_wdata_i[BCTL_ANEG];
				n.force_speed = reg_wdata_i[BCTL_SPEED];
				n.force_dup = reg_wdata_i[BCTL_DUPLEX];
				restart = reg_wdata_i[BCTL_RESTART];
			end else if (reg_addr_i == REG_ADV) begin
				n.adv_tech = s.adv_tech & reg_wdata_i[ADV_TECH_LO +: 4];
			end else if (reg_addr_i == REG_VCTL) begin
				n.sqe_dis = reg_wdata_i[VCTL_SQE_DIS];
				n.loop_en = reg_wdata_i[VCTL_LOOP];
				n.manual_pol = reg_wdata_i[VCTL_MANUAL_POL];
				n.pol_rev = reg_wdata_i[VCTL_POL_REV];
			end else if (reg_addr_i == REG_IRQ) begin
				n.irq_en = reg_wdata_i[IRQ_EN_LO +: 8];
			end else if (reg_addr_i == REG_LED) begin
				n.led_cfg = reg_wdata_i[7:0];
			end
		end

		// Acknowledge is masked so that words differing only there still match.
		word = line_rx_i.flp_word;
		word[ADV_ACK] = 1'b0;
		common = s.adv_tech & s.partner[ADV_TECH_LO +: 4];
		case (s.an)
			AN_OFF: begin
				n.link_up = line_rx_i.link_ok;
				n.speed100 = s.force_speed;
				n.full_dup = s.force_dup;
				go = n.aneg_en;
			end
			AN_ABILITY: begin
				n.an_timer = s.an_timer + 32'h1;
				n.link_up = 1'b0;
				if (line_rx_i.idle100 || line_rx_i.idle10) begin
					n.an = AN_LINK;
					n.speed100 = line_rx_i.idle100;
					n.full_dup = 1'b0;
					n.link_up = 1'b1;
					n.an_fail = 1'b0;
					ev[IRQ_AN_DONE] = 1'b1;
				end else if (line_rx_i.flp_valid) begin
					if (s.match_cnt != 2'h0 && word == s.last_word) begin
						n.match_cnt = s.match_cnt + 2'h1;
						if (s.match_cnt == MATCH_LAST) begin
							n.partner = line_rx_i.flp_word;
							n.an = AN_ACK;
							n.match_cnt = 2'h0;
							n.an_timer = '0;
							ev[IRQ_PAGE_RX] = 1'b1;
						end
					end else begin
						n.last_word = word;
						n.match_cnt = 2'h1;
					end
				end else if (s.an_timer >= AN_TIMEOUT - 32'h1) begin
					fail = 1'b1;
				end
			end
			AN_ACK: begin
				n.an_timer = s.an_timer + 32'h1;
				if (line_rx_i.flp_valid && line_rx_i.flp_word[ADV_ACK]) begin
					if (s.match_cnt != 2'h0 && word == s.last_word) begin
						n.match_cnt = s.match_cnt + 2'h1;
						if (s.match_cnt == MATCH_LAST) begin
							if (common == 4'h0) begin
								fail = 1'b1;
							end else begin
								n.an = AN_LINK;
								n.link_up = 1'b1;
								n.an_fail = 1'b0;
								n.speed100 = common[3] | common[2];
								n.full_dup = common[3] | (~common[2] & common[1]);
								ev[IRQ_AN_DONE] = 1'b1;
							end
						end
					end else begin
						n.last_word = word;
						n.match_cnt = 2'h1;
					end
				end else if (s.an_timer >= AN_TIMEOUT - 32'h1) begin
					fail = 1'b1;
				end
			end
			AN_LINK: begin
				if (!line_rx_i.link_ok) begin
					n.link_up = 1'b0;
					go = 1'b1;
				end
			end
			default: begin
				n.an = AN_OFF;
			end
		endcase
		if (fail) begin
			n.an_fail = 1'b1;
			ev[IRQ_AN_FAIL] = 1'b1;
			go = 1'b1;
		end
		if (!n.aneg_en) begin
			n.an = AN_OFF;
		end else if (go || restart) begin
			n.an = AN_ABILITY;
			n.link_up = 1'b0;
			n.match_cnt = 2'h0;
			n.an_timer = '0;
		end

		////////////////////////////////////////////////////////////////////
		// jabber entry and exit
		if (s.jabber) begin
			n.jab_cnt = tx_en_i ? 32'h0 : s.jab_cnt + 32'h1;
			if (!tx_en_i && s.jab_cnt >= JABBER_IDLE - 32'h1) begin
				n.jabber = 1'b0;
				n.jab_cnt = '0;
			end
		end else if (tx_en_i) begin
			n.jab_cnt = s.jab_cnt + 32'h1;
			if (s.jab_cnt >= JABBER_LIMIT - 32'h1) begin
				n.jabber = 1'b1;
				n.jab_cnt = '0;
				ev[IRQ_JABBER] = 1'b1;
			end
		end else begin
			n.jab_cnt = '0;
		end

		n.tx_en_d = tx_en_i;
		if (tx_en_i && !s.tx_en_d) begin
			n.col_seen = 1'b0;
		end
		if (tx_en_i && line_rx_i.collision) begin
			n.col_seen = 1'b1;
		end
		if (s.tx_en_d && !tx_en_i && !s.speed100 && !s.sqe_dis && !s.col_seen) begin
			n.sqe_run = 1'b1;
			n.sqe_cnt = '0;
		end else if (s.sqe_run) begin
			n.sqe_cnt = s.sqe_cnt + 7'h1;
			if (s.sqe_cnt == SQE_END_CYC) begin
				n.sqe_run = 1'b0;
			end
		end
		n.mii_col = line_rx_i.collision | (s.sqe_run & (s.sqe_cnt >= SQE_DELAY_CYC));

		lb = s.loop_en && !s.speed100 && !s.full_dup && tx_en_i && !line_rx_i.rx_active;
		lb = lb && !line_rx_i.collision;
		n.mii_rxd = lb ? txd_i : line_rx_i.data;
		n.mii_dv = lb ? 1'b1 : line_rx_i.dv;

		pol = s.manual_pol ? s.pol_rev : line_rx_i.inverted;
		ev[IRQ_POL_CHG] = pol != s.tx.pol_inv;
		n.tx.pol_inv = pol;

		n.tx.tx_en = tx_en_i && !n.jabber;
		n.tx.txd = txd_i;
		n.tx.flp_send = (n.an == AN_ABILITY) || (n.an == AN_ACK);
		n.tx.flp_word = {1'b0, n.an == AN_ACK, 5'h00, s.adv_tech, ADV_SELECTOR};
		n.tx.link_pulse = n.tx.flp_send || (n.link_up && !n.speed100 && !tx_en_i);

		ev[IRQ_LINK_CHG] = n.link_up != s.link_up;
		// clear on read, new event wins
		n.irq_stat = ((reg_rd_i && reg_addr_i == REG_IRQ) ? 8'h00 : s.irq_stat) | (ev & s.irq_en);
		n.irq = |n.irq_stat;

		n.link_led = led_sel(s.led_cfg[3:0], s, tx_en_i | line_rx_i.rx_active);
		n.act_led = led_sel(s.led_cfg[ACT_LED_LO +: 4], s, tx_en_i | line_rx_i.rx_active);

		if (reg_rd_i) begin
			if (reg_addr_i == REG_BCTL) begin
				r[BCTL_ANEG] = s.aneg_en;
				r[BCTL_SPEED] = s.force_speed;
				r[BCTL_DUPLEX] = s.force_dup;
			end else if (reg_addr_i == REG_ADV) begin
				r[ADV_TECH_LO +: 4] = s.adv_tech;
				r[4:0] = ADV_SELECTOR;
			end else if (reg_addr_i == REG_PARTNER) begin
				r = s.partner;
			end else if (reg_addr_i == REG_VCTL) begin
				r[VCTL_SQE_DIS] = s.sqe_dis;
				r[VCTL_LOOP] = s.loop_en;
				r[VCTL_MANUAL_POL] = s.manual_pol;
				r[VCTL_POL_REV] = s.tx.pol_inv;
			end else if (reg_addr_i == REG_IRQ) begin
				r = {s.irq_en, s.irq_stat};
			end else if (reg_addr_i == REG_DIAG) begin
				r[DIAG_FAIL] = s.an_fail;
				r[DIAG_DUPLEX] = s.full_dup;
				r[DIAG_SPEED] = s.speed100;
			end else if (reg_addr_i == REG_LED) begin
				r[7:0] = s.led_cfg;
			end
		end
		n.rdata = r;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			s <= reset_state(technology_straps_i);
		end else begin
			s <= n;
		end
	end

	assign reg_rdata_o = s.rdata;
	assign line_tx_o = s.tx;
	assign mii_col_o = s.mii_col;
	assign mii_rxd_o = s.mii_rxd;
	assign mii_rx_dv_o = s.mii_dv;
	assign link_up_o = s.link_up;
	assign speed_100_o = s.speed100;
	assign full_duplex_o = s.full_dup;
	assign link_indicator_pin_o = s.link_led;
	assign activity_indicator_pin_o = s.act_led;
	assign phy_irq_o = s.irq;

	////////////////////////////////////////////////////////////////////////

	localparam int A_SQE_ON = 41;

	a_jabber_blocks_tx: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s.jabber |-> !line_tx_o.tx_en) else $error("transmit passed during jabber");
	a_sqe_pulse_time: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(s.sqe_run) |-> ##A_SQE_ON mii_col_o) else $error("heartbeat missing");
	a_sqe_disabled: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s.sqe_dis && !s.sqe_run |=> !s.sqe_run) else $error("heartbeat while disabled");
	a_manual_pol: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s.manual_pol |=> line_tx_o.pol_inv == $past(s.pol_rev)) else $error("manual polarity ignored");
	a_loop_data: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(s.loop_en && !s.speed100 && !s.full_dup && tx_en_i && !line_rx_i.rx_active
		&& !line_rx_i.collision) |=> mii_rxd_o == $past(txd_i) && mii_rx_dv_o)
		else $error("loopback data wrong");
	a_aneg_reset_on: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$past(rst_i) |-> s.aneg_en && s.an == AN_ABILITY) else $error("negotiation off after reset");
	a_adv_clear_only: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> (s.adv_tech & ~$past(s.adv_tech)) == 4'h0) else $error("advertised bit set");
	a_restart_cmd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		reg_wr_i && reg_addr_i == REG_BCTL && reg_wdata_i[BCTL_RESTART] && reg_wdata_i[BCTL_ANEG]
		|=> s.an == AN_ABILITY && !link_up_o) else $error("restart ignored");
	a_irq_read_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == REG_IRQ |=> (s.irq_stat & ~$past(ev)) == 8'h00
		&& (phy_irq_o == |s.irq_stat)) else $error("interrupt status not cleared");
	a_read_window: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data outside window");

endmodule

/* verilog/phy_link_pkg.sv */
package phy_link_pkg;

	// Management register numbers.
	localparam logic [4:0] REG_BCTL = 5'h00;
	localparam logic [4:0] REG_ADV = 5'h04;
	localparam logic [4:0] REG_PARTNER = 5'h05;
	localparam logic [4:0] REG_VCTL = 5'h10;
	localparam logic [4:0] REG_IRQ = 5'h11;
	localparam logic [4:0] REG_DIAG = 5'h12;
	localparam logic [4:0] REG_LED = 5'h17;

	// Field positions.
	localparam int BCTL_DUPLEX = 8;
	localparam int BCTL_RESTART = 9;
	localparam int BCTL_ANEG = 12;
	localparam int BCTL_SPEED = 13;
	localparam int ADV_TECH_LO = 5;
	localparam int ADV_ACK = 14;
	localparam int VCTL_POL_REV = 4;
	localparam int VCTL_MANUAL_POL = 5;
	localparam int VCTL_LOOP = 10;
	localparam int VCTL_SQE_DIS = 11;
	localparam int IRQ_EN_LO = 8;
	localparam int DIAG_SPEED = 10;
	localparam int DIAG_DUPLEX = 11;
	localparam int DIAG_FAIL = 12;
	localparam int ACT_LED_LO = 4;

	// Interrupt status bit positions.
	localparam int IRQ_AN_DONE = 0;
	localparam int IRQ_LINK_CHG = 1;
	localparam int IRQ_AN_FAIL = 2;
	localparam int IRQ_JABBER = 3;
	localparam int IRQ_PAGE_RX = 4;
	localparam int IRQ_POL_CHG = 5;

	// Reset values and codes.
	localparam logic [4:0] ADV_SELECTOR = 5'h01;
	localparam logic [3:0] TECH_ALL = 4'hF;
	localparam logic [3:0] TECH_10HD = 4'h1;
	localparam logic [2:0] STRAP_ALL = 3'h7;
	localparam logic [7:0] LED_CFG_RESET = 8'h10;
	localparam logic [3:0] LED_LINK = 4'h0;
	localparam logic [3:0] LED_ACT = 4'h1;
	localparam logic [3:0] LED_SPEED = 4'h2;
	localparam logic [3:0] LED_DUPLEX = 4'h3;
	localparam logic [3:0] LED_COL = 4'h4;
	localparam logic [1:0] MATCH_LAST = 2'h2;

	// Timing, in the unit printed, and derived cycle counts at 40 MHz.
	localparam int CLK_PERIOD_NS = 25;
	localparam int SQE_DELAY_NS = 1000;
	localparam int SQE_WIDTH_NS = 1000;
	localparam int JABBER_IDLE_MS = 500;
	localparam int JABBER_LIMIT_MS = 50;
	localparam int AN_TIMEOUT_MS = 1000;
	localparam logic [6:0] SQE_DELAY_CYC = 7'(SQE_DELAY_NS / CLK_PERIOD_NS);
	localparam logic [6:0] SQE_END_CYC = 7'((SQE_DELAY_NS + SQE_WIDTH_NS) / CLK_PERIOD_NS - 1);
	localparam logic [31:0] JABBER_IDLE_CYC = 32'(JABBER_IDLE_MS * 1000000 / CLK_PERIOD_NS);
	localparam logic [31:0] JABBER_LIMIT_CYC = 32'(JABBER_LIMIT_MS * 1000000 / CLK_PERIOD_NS);
	localparam logic [31:0] AN_TIMEOUT_CYC = 32'(AN_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS);

	typedef enum logic [2:0] {
		AN_OFF = 3'b000,
		AN_ABILITY = 3'b001,
		AN_ACK = 3'b010,
		AN_LINK = 3'b011
	} an_state_t;

	typedef struct packed {
		logic idle10;
		logic idle100;
		logic flp_valid;
		logic [15:0] flp_word;
		logic link_ok;
		logic rx_active;
		logic collision;
		logic inverted;
		logic [3:0] data;
		logic dv;
	} line_rx_t;

	typedef struct packed {
		logic tx_en;
		logic [3:0] txd;
		logic link_pulse;
		logic flp_send;
		logic [15:0] flp_word;
		logic pol_inv;
	} line_tx_t;

endpackage
